/* src/asbl_host.sv */
`timescale 1ns/100ps
module asbl_host (
   input  wire logic                          SYS_CLK,
   input  wire logic                          RESET,
   input  wire asbl_pkg::asbl_req_t           REQ,
   input  wire logic                          REQ_VALID,
   output logic                               REQ_READY,
   output logic [asbl_pkg::DATA_W-1:0]        RD_DATA,
   output logic                               RD_VALID,
   output logic [asbl_pkg::ADDR_W-1:0]        WORD_ADDRESS,
   output asbl_pkg::asbl_strobe_t             STROBES,
   input  wire logic [asbl_pkg::DATA_W-1:0]   DATA_BUS_IN,
   output logic [asbl_pkg::DATA_W-1:0]        DATA_BUS_OUT,
   output logic [1:0]                         DATA_BUS_OE
);
   typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR, ST_WR_END} asbl_state_t;

   asbl_state_t                       state_q, state_d;
   logic [asbl_pkg::ADDR_W-1:0]       addr_q, addr_d;
   logic [asbl_pkg::DATA_W-1:0]       wdata_q, wdata_d;
   logic [asbl_pkg::DATA_W-1:0]       rdata_q, rdata_d;
   logic [1:0]                        lanes_q, lanes_d;
   logic                              rvalid_q, rvalid_d;
   asbl_pkg::asbl_strobe_t            stb_q, stb_d;
   logic [1:0]                        oe_q, oe_d;
   logic                              t_start;
   logic [1:0]                        t_len;
   logic                              t_done;

   // Keep byte lanes of the old word where the strobe is inactive
   function automatic logic [asbl_pkg::DATA_W-1:0] lane_merge(
      input logic [asbl_pkg::DATA_W-1:0] nw,
      input logic [asbl_pkg::DATA_W-1:0] old,
      input logic [1:0]                  ln);
      lane_merge = {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
   endfunction : lane_merge

   asbl_tick u_tick (
      .clk   (SYS_CLK),
      .rst   (RESET),
      .start (t_start),
      .len   (t_len),
      .done  (t_done)
   );

   assign REQ_READY    = (state_q == ST_IDLE) || (state_q == ST_WR_END);
   assign RD_DATA      = rdata_q;
   assign RD_VALID     = rvalid_q;
   assign WORD_ADDRESS = addr_q;
   assign STROBES      = stb_q;
   assign DATA_BUS_OUT = wdata_q;
   assign DATA_BUS_OE  = oe_q;

   always_comb begin
      state_d  = state_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      rdata_d  = rdata_q;
      lanes_d  = lanes_q;
      rvalid_d = 1'b0;
      stb_d    = stb_q;
      oe_d     = oe_q;
      t_start  = 1'b0;
      t_len    = asbl_pkg::CNT_RESET;
      case (state_q)
         ST_IDLE, ST_WR_END: begin
            // Lane strobes already high: write ended by them, bus released
            oe_d = 2'h0;
            if (REQ_VALID && REQ.lanes != 2'h0) begin
               addr_d  = REQ.addr;
               lanes_d = REQ.lanes;
               wdata_d = REQ.wdata;
               if (REQ.write) begin
                  if (state_q == ST_WR_END) begin
                     // Write enable kept low, lane strobes gate next write
                     state_d = ST_WR_SETUP;
                     t_start = 1'b1;
                     t_len   = 2'(asbl_pkg::ACCESS_CYC);
                  end else begin
                     stb_d.out_en_n  = 1'b1;
                     stb_d.chip_en_n = 1'b0;
                     state_d = ST_WR_SETUP;
                     t_start = 1'b1;
                     t_len   = 2'(asbl_pkg::OE_RELEASE_CYC);
                  end
               end else begin
                  stb_d.wr_en_n            = 1'b1;
                  stb_d.chip_en_n          = 1'b0;
                  stb_d.out_en_n           = 1'b0;
                  stb_d.high_lane_strobe_n = ~REQ.lanes[1];
                  stb_d.low_lane_strobe_n  = ~REQ.lanes[0];
                  state_d = ST_RD;
                  t_start = 1'b1;
                  t_len   = 2'(asbl_pkg::ACCESS_CYC);
               end
            end else begin
               stb_d   = {1'b1, 1'b1, 1'b1, asbl_pkg::STROBES_IDLE};
               state_d = ST_IDLE;
            end
         end
         ST_RD: begin
            if (t_done) begin
               rdata_d  = lane_merge(DATA_BUS_IN, 16'h0000, lanes_q);
               rvalid_d = 1'b1;
               stb_d    = {1'b1, 1'b1, 1'b1, asbl_pkg::STROBES_IDLE};
               state_d  = ST_IDLE;
            end
         end
         ST_WR_SETUP: begin
            // Output enable has been high for the release time; now drive
            stb_d.out_en_n           = 1'b1;
            stb_d.chip_en_n          = 1'b0;
            stb_d.wr_en_n            = 1'b0;
            stb_d.high_lane_strobe_n = ~lanes_q[1];
            stb_d.low_lane_strobe_n  = ~lanes_q[0];
            oe_d = lanes_q;
            if (t_done || state_q == ST_WR_SETUP && stb_q.wr_en_n == 1'b0) begin
               state_d = ST_WR;
               t_start = 1'b1;
               t_len   = 2'(asbl_pkg::ACCESS_CYC);
            end
         end
         ST_WR: begin
            if (t_done) begin
               // Lane strobes end the write; address and data held one more cycle
               stb_d.high_lane_strobe_n = 1'b1;
               stb_d.low_lane_strobe_n  = 1'b1;
               state_d = ST_WR_END;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state_q  <= ST_IDLE;
         addr_q   <= '0;
         wdata_q  <= '0;
         rdata_q  <= '0;
         lanes_q  <= 2'h0;
         rvalid_q <= 1'b0;
         stb_q    <= {1'b1, 1'b1, 1'b1, asbl_pkg::STROBES_IDLE};
         oe_q     <= 2'h0;
      end else begin
         state_q  <= state_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         rdata_q  <= rdata_d;
         lanes_q  <= lanes_d;
         rvalid_q <= rvalid_d;
         stb_q    <= stb_d;
         oe_q     <= oe_d;
      end
   end

   property p_read_we_high;
      @(posedge SYS_CLK) disable iff (RESET)
      (!stb_q.out_en_n && !stb_q.chip_en_n) |-> stb_q.wr_en_n;
   endproperty
   a_read_we_high: assert property (p_read_we_high) else $error("WE low during read");

   property p_addr_at_ce;
      @(posedge SYS_CLK) disable iff (RESET)
      // Address and chip enable launch on one edge; address must then hold
      $fell(stb_q.chip_en_n) |=> $stable(addr_q);
   endproperty
   a_addr_at_ce: assert property (p_addr_at_ce) else $error("Address moved at CE fall");

   property p_oe_before_we;
      @(posedge SYS_CLK) disable iff (RESET)
      $fell(stb_q.wr_en_n) |-> $past(stb_q.out_en_n) && stb_q.out_en_n;
   endproperty
   a_oe_before_we: assert property (p_oe_before_we) else $error("OE not high before WE");

   property p_write_end_hold;
      @(posedge SYS_CLK) disable iff (RESET)
      (state_q == ST_WR && t_done) |=> $stable(addr_q) && $stable(wdata_q) && oe_q != 2'h0;
   endproperty
   a_write_end_hold: assert property (p_write_end_hold) else $error("Data moved at write end");

   property p_no_drive_in_read;
      @(posedge SYS_CLK) disable iff (RESET)
      !stb_q.out_en_n |-> oe_q == 2'h0;
   endproperty
   a_no_drive_in_read: assert property (p_no_drive_in_read) else $error("Bus contention");

   property p_drive_lanes;
      @(posedge SYS_CLK) disable iff (RESET)
      (!stb_q.wr_en_n && !stb_q.chip_en_n) |->
         oe_q == ~{stb_q.high_lane_strobe_n, stb_q.low_lane_strobe_n} || oe_q == lanes_q;
   endproperty
   a_drive_lanes: assert property (p_drive_lanes) else $error("Lane drive mismatch");

   property p_write_all_active;
      @(posedge SYS_CLK) disable iff (RESET)
      (state_q == ST_WR) |-> !stb_q.chip_en_n && !stb_q.wr_en_n &&
         ({stb_q.high_lane_strobe_n, stb_q.low_lane_strobe_n} != 2'h3);
   endproperty
   a_write_all_active: assert property (p_write_all_active) else $error("Write not qualified");

   property p_read_done;
      @(posedge SYS_CLK) disable iff (RESET)
      (state_q == ST_IDLE && REQ_VALID && !REQ.write && REQ.lanes != 2'h0) |-> ##[1:3] RD_VALID;
   endproperty
   a_read_done: assert property (p_read_done) else $error("Read never completes");

   property p_b2b;
      @(posedge SYS_CLK) disable iff (RESET)
      (state_q == ST_WR_END && REQ_VALID && REQ.write && REQ.lanes != 2'h0)
         |=> !stb_q.wr_en_n [*2];
   endproperty
   a_b2b: assert property (p_b2b) else $error("WE rose in back-to-back");

   c_read:  cover property (@(posedge SYS_CLK) disable iff (RESET) RD_VALID);
   c_write: cover property (@(posedge SYS_CLK) disable iff (RESET) state_q == ST_WR_END);
   c_b2b:   cover property (@(posedge SYS_CLK) disable iff (RESET)
      state_q == ST_WR_END ##1 state_q == ST_WR_SETUP && !stb_q.wr_en_n);
endmodule : asbl_host

/* pkg/asbl_pkg.sv */
package asbl_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 25;
   // Output enable high before write enable falls
   localparam int OE_RELEASE_NS = 4;
   localparam int OE_RELEASE_CYC = (OE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Access strobe width; one 25 ns cycle covers 10/12 ns parts
   localparam int ACCESS_NS = 12;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] CNT_RESET = 2'h0;
   localparam logic [1:0] STROBES_IDLE = 2'h3;

   typedef struct packed {
      logic                  write;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     wdata;
      logic [1:0]            lanes;   // Bit1 high byte, bit0 low byte, active high
   } asbl_req_t;

   typedef struct packed {
      logic                  chip_en_n;
      logic                  out_en_n;
      logic                  wr_en_n;
      logic                  high_lane_strobe_n;
      logic                  low_lane_strobe_n;
   } asbl_strobe_t;
endpackage : asbl_pkg

/* src/asbl_tick.sv */
`timescale 1ns/100ps
module asbl_tick (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [1:0] len,
   output logic            done
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      // Done from the count only: start depends on done, so no loop back
      done  = (cnt_q == 2'h1);
      if (start) begin
         cnt_d = len;
      end else if (cnt_q != asbl_pkg::CNT_RESET) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= asbl_pkg::CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : asbl_tick

/* tb/asbl_sram_model.sv */
`timescale 1ns/100ps
module asbl_sram_model (
   input  wire asbl_pkg::asbl_strobe_t      strobes,
   input  wire logic [asbl_pkg::ADDR_W-1:0] word_address,
   input  wire logic [asbl_pkg::DATA_W-1:0] data_in,
   output logic [asbl_pkg::DATA_W-1:0]      data_out,
   output logic [1:0]                       data_oe
);
   logic [asbl_pkg::DATA_W-1:0] mem [logic [asbl_pkg::ADDR_W-1:0]];
   logic [asbl_pkg::DATA_W-1:0] word;
   logic [1:0]                  lane_on;
   // No clock: the write follows the strobe overlap level, as the array does
   always @(strobes or word_address or data_in) begin
      lane_on = ~{strobes.high_lane_strobe_n, strobes.low_lane_strobe_n};
      word = mem.exists(word_address) ? mem[word_address] : 16'h0000;
      if (!strobes.chip_en_n && !strobes.wr_en_n && lane_on != 2'h0) begin
         if (lane_on[0]) word[7:0] = data_in[7:0];
         if (lane_on[1]) word[15:8] = data_in[15:8];
         mem[word_address] = word;
      end
      data_out = word;
      data_oe = (!strobes.chip_en_n && !strobes.out_en_n && strobes.wr_en_n) ? lane_on : 2'h0;
   end
endmodule : asbl_sram_model

/* tb/asbl_host_test.sv */
`timescale 1ns/100ps
module asbl_host_test;
   logic                        sys_clk;
   logic                        reset;
   asbl_pkg::asbl_req_t         req;
   logic                        req_valid;
   logic                        req_ready;
   logic [asbl_pkg::DATA_W-1:0] rd_data;
   logic                        rd_valid;
   logic [asbl_pkg::ADDR_W-1:0] word_address;
   asbl_pkg::asbl_strobe_t      strobes;
   asbl_pkg::asbl_strobe_t      strobes_last;
   logic [asbl_pkg::DATA_W-1:0] bus;
   logic [asbl_pkg::DATA_W-1:0] bus_last;
   logic [asbl_pkg::DATA_W-1:0] host_out;
   logic [asbl_pkg::DATA_W-1:0] mem_out;
   logic [1:0]                  host_oe;
   logic [1:0]                  mem_oe;
   logic [15:0]                 shadow [logic [17:0]];
   int                          n_mismatch = 0;
   int                          checks = 0;

   asbl_host uut (.SYS_CLK(sys_clk), .RESET(reset), .REQ(req), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .WORD_ADDRESS(word_address), .STROBES(strobes), .DATA_BUS_IN(bus),
      .DATA_BUS_OUT(host_out), .DATA_BUS_OE(host_oe));
   asbl_sram_model mem (.strobes(strobes), .word_address(word_address), .data_in(bus),
      .data_out(mem_out), .data_oe(mem_oe));

   // Floating lanes flip each cycle so stale data cannot pass for a read
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         bus[i*8 +: 8] = host_oe[i] ? host_out[i*8 +: 8] :
                         mem_oe[i] ? mem_out[i*8 +: 8] : ~bus_last[i*8 +: 8];
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   always @(posedge sys_clk) begin
      bus_last <= bus;
      strobes_last <= strobes;
      if (!reset && !strobes.wr_en_n && strobes_last.wr_en_n)
         check(strobes_last.out_en_n, 1'b1);
      if (!reset && !strobes.chip_en_n && !strobes.out_en_n)
         check(strobes.wr_en_n, 1'b1);
   end

   // Leaves the request up; the caller drops it or chains the next one
   task automatic send(input logic wr, input logic [17:0] a, input logic [15:0] d,
                       input logic [1:0] ln);
      int n;
      n = 0;
      req = '{write: wr, addr: a, wdata: d, lanes: ln};
      req_valid = 1'b1;
      while (!req_ready && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      check(n < 20, 1'b1);
      @(negedge sys_clk);
      if (wr) shadow[a] = {ln[1] ? d[15:8] : shadow[a][15:8], ln[0] ? d[7:0] : shadow[a][7:0]};
   endtask : send

   task automatic idle;
      req_valid = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask : idle

   task automatic read_word(input logic [17:0] a, input logic [1:0] ln);
      send(1'b0, a, 16'h0000, ln);
      req_valid = 1'b0;
      // Valid pulse stands from the edge after the take until the next edge
      @(negedge sys_clk);
      check(rd_valid, 1'b1);
      check(rd_data, shadow[a] & {{8{ln[1]}}, {8{ln[0]}}});
      @(negedge sys_clk);
      check(rd_valid, 1'b0);
   endtask : read_word

   task automatic t_lanes;
      logic [17:0] a;
      for (int k = 0; k < 2; k++) begin
         a = k ? 18'h3FFFF : 18'h00000;
         send(1'b1, a, 16'hA55A, 2'h3);
         idle();
         for (int ln = 1; ln < 4; ln++) begin
            send(1'b1, a, 16'h1234 * ln[15:0], ln[1:0]);
            idle();
            read_word(a, 2'h3);
            read_word(a, ln[1:0]);
         end
      end
   endtask : t_lanes

   task automatic t_back;
      send(1'b1, 18'h00010, 16'h1111, 2'h3);
      send(1'b1, 18'h00011, 16'h2222, 2'h3);
      send(1'b1, 18'h00011, 16'h3C3C, 2'h1);
      idle();
      read_word(18'h00010, 2'h3);
      read_word(18'h00011, 2'h3);
   endtask : t_back

   task automatic t_refuse;
      req = '{write: 1'b1, addr: 18'h00010, wdata: 16'hFFFF, lanes: 2'h0};
      req_valid = 1'b1;
      repeat (6) begin
         @(negedge sys_clk);
         check(strobes.chip_en_n, 1'b1);
      end
      idle();
      read_word(18'h00010, 2'h3);
   endtask : t_refuse

   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      check({strobes, host_oe, rd_valid, req_ready}, {5'h1F, 2'h0, 1'b0, 1'b1});
      t_lanes();
      t_back();
      t_refuse();
      give_verdict();
   end
endmodule : asbl_host_test
